/* rtl/pwrs_fault_ctrl.sv */
// Fault handling and protection mode control of a PWM driven H-bridge stage.
// Assumes all pins synchronous to CLK_IN and straps static during operation.
`timescale 1ns/100ps

// Functional notes
// [R1] In self-restart mode all detectors are armed and any error sets both outputs Hi-Z.
// [R2] The self-restart delay is counted in PWM input cycles, not in clock time.
// [R3] An error in self-restart mode sets the latch, forces Hi-Z and starts the counter.
// [R4] After half the recovery count the latch clears while the outputs stay Hi-Z.
// [R5] After the full count of 512 PWM cycles switching resumes as on a reset release.
// [R6] One counter and one latch serve both half-bridges, stopping and restarting both.
// [R7] In latched shutdown mode an error holds the outputs Hi-Z until reset is toggled.
// [R8] The controller recovers a latched shutdown by driving reset low and then high.
// [R9] In protection-off mode every detector is ignored; for test use only.
// [R10] Selects 00 give self-restart, 01 latched shutdown, and 1x is reserved. The code decodes 1x as latched shutdown.
// [R11] The output strap low selects bridge-tied load; high is reserved and unused. The code holds both outputs Hi-Z while it is high.
// [R12] The board ties the straps statically to the logic rail or logic ground.
// [R13] Under reset recovery the latch clears on reset fall and switching restarts on rise.
// [R14] The fault flag is low in protection with reset high and forced high with reset low.
// [R15] The counter steps on each A-side PWM rise and restarts on a new error.
module pwrs_fault_ctrl
  import pwrs_pkg::*;
#(
  parameter int RECOVERY = RECOVERY_CYCLES
) (
  // Clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              SYS_RST_IN,
  // AHB-Lite slave
  input  wire logic              HSEL_IN,
  input  wire logic [31:0]       HADDR_IN,
  input  wire logic [1:0]        HTRANS_IN,
  input  wire logic              HWRITE_IN,
  input  wire logic [2:0]        HSIZE_IN,
  input  wire logic [31:0]       HWDATA_IN,
  input  wire logic              HREADY_IN,
  output logic      [31:0]       HRDATA_OUT,
  output logic                   HREADYOUT_OUT,
  output logic                   HRESP_OUT,
  // Front end control
  input  wire logic              RESET_N_IN,
  input  wire logic              PWM_IN_A_IN,
  input  wire logic              PWM_IN_B_IN,
  // Mode straps
  input  wire logic              PROT_SELECT_HI_IN,
  input  wire logic              PROT_SELECT_LO_IN,
  input  wire logic              OUTPUT_CONFIG_STRAP_IN,
  // Protection detectors: bit 0 overcurrent, 1 overtemperature, 2 undervoltage
  input  wire logic [ERR_W-1:0]  ERR_DETECT_IN,
  // Output stage
  output logic                   OUT_A_HIZ_OUT,
  output logic                   OUT_B_HIZ_OUT,
  output logic                   OUT_A_HIGH_OUT,
  output logic                   OUT_B_HIGH_OUT,
  // Open-drain fault flag
  input  wire logic              FAULT_FLAG_N_IN,
  output logic                   FAULT_FLAG_N_OUT,
  output logic                   FAULT_FLAG_N_OE_N_OUT,
  // Interrupt
  output logic                   IRQ_OUT
);

  localparam int CNT_W = $clog2(RECOVERY + 1);

  // Recovery counter link
  pwrs_rcv_if #(.CNT_W(CNT_W)) rcv ();

  pwrs_recovery_cnt #(
    .COUNT (RECOVERY),
    .CNT_W (CNT_W)
  ) u_recovery_cnt (
    .clk_in (CLK_IN),
    .rst_in (SYS_RST_IN),
    .rcv    (rcv)
  );

  // Control and state registers
  pwrs_state_type   state;
  pwrs_state_type   next_state;
  logic             prot_off_ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic             reset_n_prev;
  logic             pwm_a_prev;
  logic             out_hiz;
  logic             out_a_high;
  logic             out_b_high;
  logic             flag_oe_n;

  // AHB data phase registers
  logic             wr_pending;
  logic [7:0]       wr_addr;
  logic [31:0]      rdata;

  // Mode decode from straps
  pwrs_mode_type    mode;
  wire              strap_reserved = PROT_SELECT_HI_IN;
  wire              out_strap_rsv  = OUTPUT_CONFIG_STRAP_IN;
  wire              self_restart   = (mode == MODE_SELF_RESTART);

  assign mode = prot_off_ctrl         ? MODE_PROTECTION_OFF :    // R9
                (!PROT_SELECT_HI_IN && !PROT_SELECT_LO_IN) ? MODE_SELF_RESTART :  // R10 R12
                MODE_LATCHED_SHUTDOWN;                             // R10

  // Edge detection on reset and the A-side PWM input
  wire reset_fall = reset_n_prev & ~RESET_N_IN;
  wire reset_rise = ~reset_n_prev & RESET_N_IN;  // R8
  wire pwm_a_rise = PWM_IN_A_IN & ~pwm_a_prev;   // R15

  // Any armed detector, both half-bridges together
  wire err_any  = (|ERR_DETECT_IN) & (mode != MODE_PROTECTION_OFF);  // R1 R6 R9
  wire latched  = (state == ST_LATCHED);
  wire new_err  = err_any & ~latched;

  // Recovery counter control
  assign rcv.start    = err_any & self_restart;            // R3 R15
  assign rcv.stop     = (latched & reset_fall & ~err_any) | ~self_restart;
  assign rcv.pwm_edge = pwm_a_rise;                        // R2 R15

  // Protection state sequence
  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: begin
        if (err_any) begin
          next_state = ST_LATCHED;       // R1 R7
        end else if (reset_rise) begin
          next_state = ST_RUN;           // R13
        end
      end
      ST_RUN: begin
        if (err_any) begin
          next_state = ST_LATCHED;       // R1 R3 R7
        end else if (!RESET_N_IN) begin
          next_state = ST_OFF;
        end
      end
      ST_LATCHED: begin
        if (err_any) begin
          next_state = ST_LATCHED;
        end else if (reset_fall) begin
          next_state = ST_OFF;           // R13 R7
        end else if (self_restart && rcv.half_done) begin
          next_state = ST_RECOVER;       // R4
        end
      end
      ST_RECOVER: begin
        if (err_any) begin
          next_state = ST_LATCHED;       // R15
        end else if (!self_restart) begin
          next_state = ST_OFF;
        end else if (rcv.full_done) begin
          next_state = RESET_N_IN ? ST_RUN : ST_OFF;  // R5
        end
      end
    endcase
  end

  // Output stage drive
  wire next_hiz = (next_state != ST_RUN) | out_strap_rsv;  // R1 R6 R11

  // Fault flag: low only while latched with reset high
  wire next_flag_oe_n = ~((next_state == ST_LATCHED) & RESET_N_IN);  // R14

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state        <= ST_OFF;
      reset_n_prev <= 1'b0;
      pwm_a_prev   <= 1'b0;
      out_hiz      <= 1'b1;
      out_a_high   <= 1'b0;
      out_b_high   <= 1'b0;
      flag_oe_n    <= 1'b1;
    end else begin
      state        <= next_state;
      reset_n_prev <= RESET_N_IN;
      pwm_a_prev   <= PWM_IN_A_IN;
      out_hiz      <= next_hiz;
      out_a_high   <= PWM_IN_A_IN & ~next_hiz;
      out_b_high   <= PWM_IN_B_IN & ~next_hiz;
      flag_oe_n    <= next_flag_oe_n;
    end
  end

  assign OUT_A_HIZ_OUT         = out_hiz;
  assign OUT_B_HIZ_OUT         = out_hiz;
  assign OUT_A_HIGH_OUT        = out_a_high;
  assign OUT_B_HIGH_OUT        = out_b_high;
  assign FAULT_FLAG_N_OUT      = 1'b0;
  assign FAULT_FLAG_N_OE_N_OUT = flag_oe_n;

  // Interrupt events
  wire [IRQ_W-1:0] irq_event;
  assign irq_event[IRQ_ERROR_BIT]   = new_err;
  assign irq_event[IRQ_RESTART_BIT] = (state == ST_RECOVER) & (next_state == ST_RUN);
  assign irq_event[IRQ_RST_CLR_BIT] = latched & (next_state == ST_OFF);

  // AHB address phase decode
  wire        addr_phase = HSEL_IN & HREADY_IN & (HTRANS_IN == HTRANS_NONSEQ);
  wire        rd_take    = addr_phase & ~HWRITE_IN;
  wire        wr_take    = addr_phase & HWRITE_IN;
  wire [7:0]  rd_addr    = HADDR_IN[REG_ADDR_W-1:0];

  // Data phase write strobes
  wire wr_ctrl   = wr_pending & (wr_addr == CTRL_OFFSET);
  wire wr_clear  = wr_pending & (wr_addr == IRQ_CLEAR_OFFSET);
  wire wr_enable = wr_pending & (wr_addr == IRQ_ENABLE_OFFSET);

  // Sticky status: a new event wins over a clear in the same cycle
  wire [IRQ_W-1:0] irq_clr_mask = wr_clear ? HWDATA_IN[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr_mask) | irq_event;

  // Status word
  wire [31:0] status_word;
  assign status_word[ST_LATCH_BIT]                  = latched;
  assign status_word[ST_SWITCH_BIT]                 = (state == ST_RUN);
  assign status_word[ST_RECOVER_BIT]                = rcv.busy;
  assign status_word[ST_MODE_LSB+1:ST_MODE_LSB]     = mode;
  assign status_word[ST_STRAP_RSV_BIT]              = strap_reserved | out_strap_rsv;
  assign status_word[ST_FLAG_PIN_BIT]               = FAULT_FLAG_N_IN;
  assign status_word[ST_ERR_LSB+ERR_W-1:ST_ERR_LSB] = ERR_DETECT_IN;
  assign status_word[31:ST_ERR_LSB+ERR_W]           = '0;

  // Read data selection; unmapped and write-only offsets read zero
  wire [31:0] rd_mux =
    (rd_addr == CTRL_OFFSET)       ? {31'h0, prot_off_ctrl} :
    (rd_addr == STATUS_OFFSET)     ? status_word :
    (rd_addr == IRQ_STATUS_OFFSET) ? {29'h0, irq_status} :
    (rd_addr == IRQ_ENABLE_OFFSET) ? {29'h0, irq_enable} :
    (rd_addr == RECOVERY_OFFSET)   ? 32'(rcv.count) :
    32'h0;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
      rdata      <= 32'h0;
    end else begin
      wr_pending <= wr_take;
      wr_addr    <= wr_take ? rd_addr : wr_addr;
      rdata      <= rd_take ? rd_mux : rdata;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      prot_off_ctrl <= CTRL_RESET;
      irq_status    <= '0;
      irq_enable    <= IRQ_ENABLE_RESET;
    end else begin
      prot_off_ctrl <= wr_ctrl ? HWDATA_IN[CTRL_PROT_OFF_BIT] : prot_off_ctrl;  // R9
      irq_status    <= next_irq_status;
      irq_enable    <= wr_enable ? HWDATA_IN[IRQ_W-1:0] : irq_enable;
    end
  end

  assign HRDATA_OUT    = rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = HRESP_OKAY;
  assign IRQ_OUT       = |(irq_status & irq_enable);

endmodule // pwrs_fault_ctrl

/* rtl/pwrs_pkg.sv */
// Constants, register map and types of the power stage fault controller.
// Assumes a single 200 MHz clock and a zero wait state AHB-Lite slave.
package pwrs_pkg;

  // Recovery timing, in cycles of the A-side PWM input
  localparam int          RECOVERY_CYCLES   = 512;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
  localparam logic        HRESP_OKAY        = 1'h0;
  localparam int          REG_ADDR_W        = 8;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
  localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0]  IRQ_CLEAR_OFFSET  = 8'h0c;
  localparam logic [7:0]  IRQ_ENABLE_OFFSET = 8'h10;
  localparam logic [7:0]  RECOVERY_OFFSET   = 8'h14;

  // Control register fields
  localparam int          CTRL_PROT_OFF_BIT = 0;
  localparam logic        CTRL_RESET        = 1'h0;

  // Status register fields
  localparam int          ST_LATCH_BIT      = 0;
  localparam int          ST_SWITCH_BIT     = 1;
  localparam int          ST_RECOVER_BIT    = 2;
  localparam int          ST_MODE_LSB       = 3;
  localparam int          ST_STRAP_RSV_BIT  = 5;
  localparam int          ST_FLAG_PIN_BIT   = 6;
  localparam int          ST_ERR_LSB        = 7;

  // Interrupt fields, shared by status, clear and enable
  localparam int          IRQ_W             = 3;
  localparam int          IRQ_ERROR_BIT     = 0;
  localparam int          IRQ_RESTART_BIT   = 1;
  localparam int          IRQ_RST_CLR_BIT   = 2;
  localparam logic [2:0]  IRQ_ENABLE_RESET  = 3'h0;

  // Number of protection detectors: overcurrent, overtemperature, undervoltage
  localparam int          ERR_W             = 3;

  typedef enum logic [1:0] {
    MODE_SELF_RESTART,
    MODE_LATCHED_SHUTDOWN,
    MODE_PROTECTION_OFF
  } pwrs_mode_type;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_LATCHED,
    ST_RECOVER
  } pwrs_state_type;

endpackage

/* rtl/pwrs_rcv_if.sv */
// Interface between the fault controller and its recovery counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface pwrs_rcv_if #(
  parameter int CNT_W = 10
);
  logic             start;
  logic             stop;
  logic             pwm_edge;
  logic             half_done;
  logic             full_done;
  logic             busy;
  logic [CNT_W-1:0] count;

  modport ctrl (output start, stop, pwm_edge, input half_done, full_done, busy, count);
  modport cnt  (input start, stop, pwm_edge, output half_done, full_done, busy, count);
endinterface

/* rtl/pwrs_recovery_cnt.sv */
// Recovery counter: counts PWM input edges after a protection event.
// Assumes start, stop and pwm_edge are synchronous; pwm_edge is a one-cycle pulse, stop may be held high as a level.
`timescale 1ns/100ps
module pwrs_recovery_cnt
  import pwrs_pkg::*;
#(
  parameter int COUNT = RECOVERY_CYCLES,
  parameter int CNT_W = $clog2(COUNT + 1)
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Controller side
  pwrs_rcv_if.cnt   rcv
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(COUNT / 2 - 1);

  logic             busy;
  logic [CNT_W-1:0] count;
  wire              step = busy & rcv.pwm_edge & ~rcv.start & ~rcv.stop;

  assign rcv.busy      = busy;
  assign rcv.count     = count;
  assign rcv.half_done = step & (count == HALF);  // R4
  assign rcv.full_done = step & (count == LAST);  // R5

  always_ff @(posedge clk_in) begin
    if (rst_in || rcv.stop) begin
      busy  <= 1'b0;
      count <= '0;
    end else if (rcv.start) begin
      busy  <= 1'b1;  // R15
      count <= '0;    // R15
    end else if (step) begin
      busy  <= (count != LAST);
      count <= (count == LAST) ? '0 : count + CNT_W'(1);  // R2
    end
  end

endmodule // pwrs_recovery_cnt

/* test/pwrs_checker.sv */
// Port level assertions for the power stage fault controller.
// Assumes one clock domain and a bind into every controller instance.
`timescale 1ns/100ps
module pwrs_checker
  import pwrs_pkg::*;
#(
  parameter int RECOVERY = RECOVERY_CYCLES
) (
  // Clock and reset
  input wire logic             CLK_IN,
  input wire logic             SYS_RST_IN,
  // Register bus
  input wire logic             HSEL_IN,
  input wire logic [31:0]      HADDR_IN,
  input wire logic [1:0]       HTRANS_IN,
  input wire logic             HWRITE_IN,
  input wire logic [31:0]      HWDATA_IN,
  input wire logic             HREADY_IN,
  // Pins
  input wire logic             RESET_N_IN,
  input wire logic             PWM_IN_A_IN,
  input wire logic             PWM_IN_B_IN,
  input wire logic             PROT_SELECT_HI_IN,
  input wire logic             PROT_SELECT_LO_IN,
  input wire logic             OUTPUT_CONFIG_STRAP_IN,
  input wire logic [ERR_W-1:0] ERR_DETECT_IN,
  input wire logic             OUT_A_HIZ_OUT,
  input wire logic             OUT_B_HIZ_OUT,
  input wire logic             OUT_A_HIGH_OUT,
  input wire logic             OUT_B_HIGH_OUT,
  input wire logic             FAULT_FLAG_N_OE_N_OUT
);
  logic wr_ctrl;
  logic prot_off;
  logic a_q;
  int   rises;
  wire  err = |ERR_DETECT_IN && !prot_off;
  wire  sr  = !PROT_SELECT_HI_IN && !PROT_SELECT_LO_IN && !prot_off;
  wire  hit = HSEL_IN && HREADY_IN && HTRANS_IN == HTRANS_NONSEQ && HWRITE_IN;

  // Mirror of the test bit and of the rise count since the last error
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      wr_ctrl  <= 1'b0;
      prot_off <= 1'b0;
      a_q      <= 1'b0;
      rises    <= RECOVERY;
    end else begin
      wr_ctrl <= hit && HADDR_IN[7:0] == CTRL_OFFSET;
      if (wr_ctrl)
        prot_off <= HWDATA_IN[CTRL_PROT_OFF_BIT];
      a_q <= PWM_IN_A_IN;
      if (err)
        rises <= 0;
      else if (PWM_IN_A_IN && !a_q && rises < RECOVERY)
        rises <= rises + 1;
    end
  end

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence half_hit;
    $rose(rises == RECOVERY / 2);
  endsequence
  sequence full_hit;
    $rose(rises == RECOVERY);
  endsequence

  chk_err_to_hiz: assert property (err |=> OUT_A_HIZ_OUT && OUT_B_HIZ_OUT)
    else $error("outputs not high impedance after error");
  chk_halves_equal: assert property (OUT_A_HIZ_OUT == OUT_B_HIZ_OUT)
    else $error("half bridges disagree");
  chk_hiz_quiet: assert property (OUT_A_HIZ_OUT |-> !OUT_A_HIGH_OUT && !OUT_B_HIGH_OUT)
    else $error("drive seen while high impedance");
  chk_early_resume: assert property (sr && rises < RECOVERY |-> OUT_A_HIZ_OUT)
    else $error("switching resumed before full count");
  chk_half_clear: assert property ((sr and half_hit)
    |-> FAULT_FLAG_N_OE_N_OUT && OUT_A_HIZ_OUT)
    else $error("latch not cleared at half count");
  chk_full_resume: assert property ((sr and full_hit
    and RESET_N_IN && !OUTPUT_CONFIG_STRAP_IN) |-> !OUT_A_HIZ_OUT)
    else $error("switching not resumed at full count");
  chk_drive_follow: assert property (!OUT_A_HIZ_OUT |-> OUT_A_HIGH_OUT == $past(PWM_IN_A_IN)
    && OUT_B_HIGH_OUT == $past(PWM_IN_B_IN))
    else $error("output drive does not follow inputs");
  chk_latch_hold: assert property ((PROT_SELECT_HI_IN || PROT_SELECT_LO_IN) && OUT_A_HIZ_OUT
    && RESET_N_IN && $past(RESET_N_IN) && !$past(SYS_RST_IN) |=> OUT_A_HIZ_OUT)
    else $error("latched shutdown released without reset toggle");
  chk_reset_rise: assert property ($rose(RESET_N_IN) && !(|ERR_DETECT_IN)
    && !OUTPUT_CONFIG_STRAP_IN |=> !OUT_A_HIZ_OUT) else $error("no restart on reset rise");
  chk_flag_error: assert property (err && RESET_N_IN |=> !FAULT_FLAG_N_OE_N_OUT)
    else $error("fault flag not pulled low");
  chk_flag_reset: assert property (!RESET_N_IN |=> FAULT_FLAG_N_OE_N_OUT)
    else $error("fault flag not released under reset");
endmodule // pwrs_checker

bind pwrs_fault_ctrl pwrs_checker #(.RECOVERY(RECOVERY)) pwrs_checker_i (.*);

/* test/pwrs_fault_ctrl_bench.sv */
// Self-checking bench of the power stage fault controller.
// Assumes the checker is bound in and the front end model drives the PWM pins.
`timescale 1ns/100ps
module pwrs_fault_ctrl_bench;
  import pwrs_pkg::*;
  localparam int RCV = 8;
  logic        CLK_IN, SYS_RST_IN, HSEL_IN, HWRITE_IN, HREADY_IN, HREADYOUT_OUT, HRESP_OUT;
  logic [31:0] HADDR_IN, HWDATA_IN, HRDATA_OUT, rv;
  logic [1:0]  HTRANS_IN;
  logic [2:0]  HSIZE_IN, ERR_DETECT_IN;
  logic        RESET_N_IN, PWM_IN_A_IN, PWM_IN_B_IN, IRQ_OUT;
  logic        PROT_SELECT_HI_IN, PROT_SELECT_LO_IN, OUTPUT_CONFIG_STRAP_IN;
  logic        OUT_A_HIZ_OUT, OUT_B_HIZ_OUT, OUT_A_HIGH_OUT, OUT_B_HIGH_OUT;
  logic        FAULT_FLAG_N_IN, FAULT_FLAG_N_OUT, FAULT_FLAG_N_OE_N_OUT, a_q;
  int          failures, comparisons, rises;

  assign HREADY_IN = HREADYOUT_OUT;
  assign FAULT_FLAG_N_IN = FAULT_FLAG_N_OE_N_OUT ? 1'b1 : FAULT_FLAG_N_OUT;

  pwrs_fault_ctrl #(.RECOVERY(RCV)) pwrs_fault_ctrl_i (.*);
  pwrs_front_end pwrs_front_end_i (.clk_in(CLK_IN), .rst_in(SYS_RST_IN),
    .pwm_a_out(PWM_IN_A_IN), .pwm_b_out(PWM_IN_B_IN), .reset_n_out(RESET_N_IN));

  initial begin
    CLK_IN = 1'b0;
    forever #2.5 CLK_IN = ~CLK_IN;
  end

  // Rises of the A input since the last error
  always @(posedge CLK_IN) begin
    a_q <= PWM_IN_A_IN;
    if (|ERR_DETECT_IN)
      rises <= 0;
    else if (PWM_IN_A_IN && !a_q)
      rises <= rises + 1;
  end

  task end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task wait_for(input logic v);
    int n;
    for (n = 0; n < 2000 && OUT_A_HIZ_OUT !== v; n++) begin
      @(posedge CLK_IN);
      #1;
    end
    if (n == 2000) begin
      failures++;
      end_of_test;
    end
  endtask

  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge CLK_IN);
      n++;
    end while (HREADY_IN !== 1'b1 && n < 50);
    if (HREADY_IN !== 1'b1) begin
      failures++;
      end_of_test;
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL_IN <= 1'b1;
    HTRANS_IN <= HTRANS_NONSEQ;
    HADDR_IN <= {24'h0, a};
    HWRITE_IN <= w;
    wait_ready;
    HSEL_IN <= 1'b0;
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= wd;
    wait_ready;
    rv = HRDATA_OUT;
    check(32'(HRESP_OUT), 32'(HRESP_OKAY));
  endtask

  // Straps change only while the system reset is held
  task restart(input logic [2:0] m);
    SYS_RST_IN <= 1'b1;
    {PROT_SELECT_HI_IN, PROT_SELECT_LO_IN, OUTPUT_CONFIG_STRAP_IN} <= m;
    repeat (16) @(posedge CLK_IN);
    SYS_RST_IN <= 1'b0;
    repeat (4) @(posedge CLK_IN);
    #1;
  endtask

  task inject(input logic [2:0] e);
    ERR_DETECT_IN <= e;
    @(posedge CLK_IN);
    ERR_DETECT_IN <= 3'h0;
    @(posedge CLK_IN);
    #1;
  endtask

  initial begin
    {HSEL_IN, HWRITE_IN, HTRANS_IN, HADDR_IN, HWDATA_IN, ERR_DETECT_IN} = '0;
    HSIZE_IN = 3'h2;
    restart(3'h0);
    check(32'(OUT_A_HIZ_OUT), 32'h0);
    ahb(1'b0, IRQ_ENABLE_OFFSET, 32'h0);
    check(rv, 32'(IRQ_ENABLE_RESET));
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(rv[ST_MODE_LSB +: 2]), 32'h0);
    ahb(1'b1, IRQ_ENABLE_OFFSET, 32'h7);
    for (int d = 0; d < ERR_W; d++) begin
      inject(3'(1 << d));
      check(32'({OUT_A_HIZ_OUT, OUT_B_HIZ_OUT, FAULT_FLAG_N_OE_N_OUT, IRQ_OUT}), 32'hd);
      repeat (20) @(posedge CLK_IN);
      inject(3'(1 << d));
      wait_for(1'b0);
      check(32'(rises), RCV);
      ahb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
      check(rv, 32'h3);
      ahb(1'b1, IRQ_CLEAR_OFFSET, 32'h7);
      #1;
      check(32'(IRQ_OUT), 32'h0);
    end
    ahb(1'b1, IRQ_ENABLE_OFFSET, 32'h0);
    inject(3'h2);
    check(32'({OUT_A_HIZ_OUT, IRQ_OUT}), 32'h2);
    wait_for(1'b0);
    for (int k = 1; k < 4; k++) begin
      restart({2'(k), 1'b0});
      inject(3'h4);
      repeat (3 * RCV * 4) @(posedge CLK_IN);
      #1;
      check(32'({OUT_A_HIZ_OUT, FAULT_FLAG_N_IN}), 32'h2);
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      check(32'(rv[ST_MODE_LSB +: 2]), 32'h1);
      check(32'(rv[ST_LATCH_BIT]), 32'h1);
      pwrs_front_end_i.drive_reset(1'b0);
      repeat (4) @(posedge CLK_IN);
      #1;
      check(32'({OUT_A_HIZ_OUT, FAULT_FLAG_N_IN}), 32'h3);
      ahb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
      check(rv, 32'h5);
      pwrs_front_end_i.drive_reset(1'b1);
      repeat (3) @(posedge CLK_IN);
      #1;
      check(32'(OUT_A_HIZ_OUT), 32'h0);
    end
    restart(3'h1);
    repeat (20) @(posedge CLK_IN);
    #1;
    check(32'({OUT_A_HIZ_OUT, OUT_A_HIGH_OUT, OUT_B_HIGH_OUT}), 32'h4);
    restart(3'h0);
    ahb(1'b1, CTRL_OFFSET, 32'h1);
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(rv[ST_MODE_LSB +: 2]), 32'h2);
    inject(3'h7);
    check(32'({OUT_A_HIZ_OUT, FAULT_FLAG_N_OE_N_OUT}), 32'h1);
    end_of_test;
  end
endmodule // pwrs_fault_ctrl_bench

/* test/pwrs_front_end.sv */
// Model of the PWM modulator front end that feeds the power stage.
// Assumes the bench clock; reset level is changed through drive_reset.
`timescale 1ns/100ps
module pwrs_front_end (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Pins toward the power stage
  output logic      pwm_a_out,
  output logic      pwm_b_out,
  output logic      reset_n_out
);
  logic [1:0] phase;

  initial reset_n_out = 1'b1;

  // Free running switching; while rst_in is set, A is held low and B is held high
  always_ff @(posedge clk_in) begin
    if (rst_in)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end
  assign pwm_a_out = phase[1];
  assign pwm_b_out = !phase[1];

  // Recovery from shutdown: reset driven low, later high again
  task drive_reset(input logic level);
    @(posedge clk_in);
    reset_n_out <= level;
  endtask
endmodule // pwrs_front_end
